// ---- logic/lsfm_monitor.sv ----
// Purpose: Watches limit and reference switches for inconsistent signals.
// Assumes: Motion state comes from logic on core_clk; pins are asynchronous.
// Notes:   Errors latch until err_clear; a new event in that cycle wins.
`timescale 1ns/1ps
`default_nettype none
module lsfm_monitor #(
	parameter int unsigned MIN_CYC = lsfm_pkg::SW_MIN_CYC
) (
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	input  wire logic                   positive_limit_input,
	input  wire logic                   negative_limit_input,
	input  wire logic                   ref_switch_input,
	input  wire lsfm_pkg::lsfm_motion_t motion,
	input  wire logic                   err_clear,
	output lsfm_pkg::lsfm_err_t         err_q,
	output logic [15:0]                 err_code_q,
	output logic [3:0]                  err_class_q,
	output logic [15:0]                 status_q
);
	logic [lsfm_pkg::N_CH-1:0] pin;
	logic [lsfm_pkg::N_CH-1:0] act;
	logic [lsfm_pkg::N_CH-1:0] rise;
	logic [lsfm_pkg::N_CH-1:0] fault;
	lsfm_pkg::lsfm_err_t       set_v;
	lsfm_pkg::lsfm_err_t       err_d;
	logic                      multi_act;
	logic                      any_err;
	logic [15:0]               code_d;
	logic [15:0]               status_d;

	assign pin[lsfm_pkg::CH_POS]  = positive_limit_input;
	assign pin[lsfm_pkg::CH_NEG]  = negative_limit_input;
	assign pin[lsfm_pkg::CH_REF]  = ref_switch_input;

	// One conditioner per switch input.
	for (genvar i = 0; i < lsfm_pkg::N_CH; i++)
	begin : g_ch
		lsfm_sw_chan #(
			.MIN_CYC (MIN_CYC)
		) u_chan (
			.core_clk (core_clk),
			.rstn     (rstn),
			.pin      (pin[i]),
			.moving   (motion.moving),
			.act_q    (act[i]),
			.rise_q   (rise[i]),
			.fault_q  (fault[i])
		);
	end

	// Error detection from the conditioned switch levels and events.
	assign multi_act = (act[0] & act[1]) | (act[0] & act[2])
		| (act[1] & act[2]);
	assign set_v.multi      = multi_act;
	assign set_v.pos_dir    = rise[lsfm_pkg::CH_POS] & motion.moving
		& motion.dir_neg;
	assign set_v.neg_dir    = rise[lsfm_pkg::CH_NEG] & motion.moving
		& ~motion.dir_neg;
	assign set_v.ref_brief  = fault[lsfm_pkg::CH_REF];
	assign set_v.pos_brief  = fault[lsfm_pkg::CH_POS];
	assign set_v.neg_brief  = fault[lsfm_pkg::CH_NEG];

	// Sticky flags: a clear drops them, a new event in the same cycle wins.
	assign err_d   = (err_q & ~{$bits(err_q){err_clear}}) | set_v;
	assign any_err = |err_d;

	// Reported code: the lowest-numbered pending error.
	assign code_d = err_d.multi      ? lsfm_pkg::ERR_MULTI      :
	                err_d.pos_dir    ? lsfm_pkg::ERR_POS_DIR    :
	                err_d.neg_dir    ? lsfm_pkg::ERR_NEG_DIR    :
	                err_d.ref_brief  ? lsfm_pkg::ERR_REF_BRIEF  :
	                err_d.pos_brief  ? lsfm_pkg::ERR_POS_BRIEF  :
	                err_d.neg_brief  ? lsfm_pkg::ERR_NEG_BRIEF  :
	                lsfm_pkg::ERR_NONE;

	// Every switch error is class 1 and shows on status bit 10.
	always_comb
	begin
		status_d = lsfm_pkg::STATUS_RESET;
		status_d[lsfm_pkg::STATUS_ERR_BIT] = any_err;
	end

	// Output registers.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			err_q       <= lsfm_pkg::ERR_RESET;
			err_code_q  <= lsfm_pkg::ERR_NONE;
			err_class_q <= lsfm_pkg::CLASS_NONE;
			status_q    <= lsfm_pkg::STATUS_RESET;
		end
		else
		begin
			err_q       <= err_d;
			err_code_q  <= code_d;
			err_class_q <= any_err ? lsfm_pkg::ERR_CLASS
				: lsfm_pkg::CLASS_NONE;
			status_q    <= status_d;
		end
	end

	// Checks on the latched errors and their report.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_pos_wrong;
		rise[lsfm_pkg::CH_POS] && motion.moving && motion.dir_neg;
	endsequence

	sequence s_neg_wrong;
		rise[lsfm_pkg::CH_NEG] && motion.moving && !motion.dir_neg;
	endsequence

	sequence s_err_report;
		status_q[lsfm_pkg::STATUS_ERR_BIT] && (err_class_q == 4'h1);
	endsequence

	a_multi_switch: assert property (
		multi_act |=> err_q.multi ##0 s_err_report
			##0 (err_code_q == 16'hA329))
		else $error("Two active switches did not raise the multi error.");

	a_pos_direction: assert property (
		s_pos_wrong |=> err_q.pos_dir ##0 s_err_report)
		else $error("Positive limit in negative travel was not flagged.");

	a_neg_direction: assert property (
		s_neg_wrong |=> err_q.neg_dir ##0 s_err_report)
		else $error("Negative limit in positive travel was not flagged.");

	a_ref_brief: assert property (
		fault[lsfm_pkg::CH_REF] |=> err_q.ref_brief ##0 s_err_report)
		else $error("Reference switch fault was not latched.");

	a_pos_brief: assert property (
		fault[lsfm_pkg::CH_POS] |=> err_q.pos_brief ##0 s_err_report)
		else $error("Positive limit fault was not latched.");

	a_neg_brief: assert property (
		fault[lsfm_pkg::CH_NEG] |=> err_q.neg_brief ##0 s_err_report)
		else $error("Negative limit fault was not latched.");

	a_latch_hold: assert property (
		(err_q != '0) && !err_clear |=> (err_q & $past(err_q))
			== $past(err_q))
		else $error("A latched error dropped without a clear.");

	a_clear_empty: assert property (
		err_clear && (set_v == '0) |=> (err_q == '0)
			&& !status_q[lsfm_pkg::STATUS_ERR_BIT] ##1 1'b1)
		else $error("Clear with no new event left an error standing.");

	a_clear_race: assert property (
		err_clear && set_v.multi |=> err_q.multi)
		else $error("An event in the clear cycle was lost.");

endmodule : lsfm_monitor
`default_nettype wire

// ---- logic/lsfm_pkg.sv ----
// Purpose: Shared constants and types of the limit switch fault monitor.
// Assumes: Core clock of 125 MHz; switch inputs are active high.
// Notes:   Error codes, class and status bit position are named here once.
`default_nettype none
package lsfm_pkg;

	// Core clock rate and the least time a switch must stay active.
	localparam int unsigned CLK_MHZ          = 125;
	localparam int unsigned SW_MIN_ACTIVE_US = 1000;
	localparam int unsigned SW_MIN_CYC       = SW_MIN_ACTIVE_US * CLK_MHZ;
	localparam int unsigned CNT_W            = 20;

	// Switch channel indices.
	localparam int unsigned CH_POS  = 0;
	localparam int unsigned CH_NEG  = 1;
	localparam int unsigned CH_REF  = 2;
	localparam int unsigned N_CH    = 3;

	// Error codes, their class and the status bit that reports them.
	localparam logic [15:0] ERR_NONE       = 16'h0000;
	localparam logic [15:0] ERR_MULTI      = 16'hA329;
	localparam logic [15:0] ERR_POS_DIR    = 16'hA32A;
	localparam logic [15:0] ERR_NEG_DIR    = 16'hA32B;
	localparam logic [15:0] ERR_REF_BRIEF  = 16'hA32C;
	localparam logic [15:0] ERR_POS_BRIEF  = 16'hA32D;
	localparam logic [15:0] ERR_NEG_BRIEF  = 16'hA32E;
	localparam logic [3:0]  ERR_CLASS      = 4'h1;
	localparam logic [3:0]  CLASS_NONE     = 4'h0;
	localparam int unsigned STATUS_ERR_BIT = 10;
	localparam logic [15:0] STATUS_RESET   = 16'h0000;

	// Motion state from the drive's own controller.
	typedef struct packed {
		logic moving;
		logic dir_neg;
	} lsfm_motion_t;

	// Latched switch errors, one flag each.
	typedef struct packed {
		logic neg_brief;
		logic pos_brief;
		logic ref_brief;
		logic neg_dir;
		logic pos_dir;
		logic multi;
	} lsfm_err_t;

	localparam lsfm_err_t ERR_RESET = '0;

endpackage : lsfm_pkg
`default_nettype wire

// ---- logic/lsfm_sw_chan.sv ----
// Purpose: One switch input: synchroniser, edge and brief-pulse detection.
// Assumes: The pin is asynchronous to core_clk.
// Notes:   A fall after a short pulse, or while moving, flags a fault.
`timescale 1ns/1ps
`default_nettype none
module lsfm_sw_chan #(
	parameter int unsigned MIN_CYC = lsfm_pkg::SW_MIN_CYC
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic pin,
	input  wire logic moving,
	output logic      act_q,
	output logic      rise_q,
	output logic      fault_q
);
	logic                     sync1_q;
	logic                     sync2_q;
	logic [lsfm_pkg::CNT_W-1:0] cnt_q;
	logic [lsfm_pkg::CNT_W-1:0] cnt_d;
	logic                     fall;
	logic                     short_act;
	logic                     sat;

	// Edge and duration decode on the synchronised level.
	assign fall      = act_q & ~sync2_q;
	assign sat       = (cnt_q == {lsfm_pkg::CNT_W{1'b1}});
	assign short_act = (cnt_q < lsfm_pkg::CNT_W'(MIN_CYC));
	assign cnt_d     = !sync2_q ? '0 : (sat ? cnt_q : cnt_q + 1'b1);

	// Two flip-flops take the pin into the clock domain.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= pin;
			sync2_q <= sync1_q;
		end
	end

	// Active length counter and the event flags.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			act_q   <= 1'b0;
			rise_q  <= 1'b0;
			fault_q <= 1'b0;
			cnt_q   <= '0;
		end
		else
		begin
			act_q   <= sync2_q;
			rise_q  <= sync2_q & ~act_q;
			fault_q <= fall & (short_act | moving); // Brief or passed over.
			cnt_q   <= cnt_d;
		end
	end

endmodule : lsfm_sw_chan
`default_nettype wire

// ---- tb/lsfm_switch_model.sv ----
// Purpose: Model of the switch set that drives the three switch pins.
// Assumes: Switches are active high and fall back to low when open.
// Notes:   Pins follow the bench command one clock edge later.
`timescale 1ns/1ps
`default_nettype none
module lsfm_switch_model (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic [2:0] cmd,
	output logic            pos_lim,
	output logic            neg_lim,
	output logic            ref_sw
);
	// Open switches while in reset, then follow the command.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			{ref_sw, neg_lim, pos_lim} <= 3'h0;
		else
			{ref_sw, neg_lim, pos_lim} <= cmd;
	end
endmodule : lsfm_switch_model
`default_nettype wire

// ---- tb/limit_switch_fault_monitor_tb.sv ----
// Purpose: Self-checking bench of the switch fault monitor.
// Assumes: Short minimum active time so brief pulses stay cheap.
// Notes:   Expected errors are built from the pulses the bench sends.
`timescale 1ns/1ps
`default_nettype none
module limit_switch_fault_monitor_tb;
	localparam int unsigned MIN = 8;
	logic                   core_clk   = 1'b0;
	logic                   rstn       = 1'b0;
	logic [2:0]             sw_cmd     = 3'h0;
	logic                   err_clear  = 1'b0;
	lsfm_pkg::lsfm_motion_t motion     = '0;
	logic                   pos_lim;
	logic                   neg_lim;
	logic                   ref_sw;
	lsfm_pkg::lsfm_err_t    err_q;
	logic [15:0]            err_code_q;
	logic [3:0]             err_class_q;
	logic [15:0]            status_q;
	lsfm_pkg::lsfm_err_t    e;
	int                     failures   = 0;
	int                     num_checks = 0;

	// Free running core clock.
	always #4 core_clk = ~core_clk;

	lsfm_switch_model u_sw (.core_clk(core_clk), .rstn(rstn), .cmd(sw_cmd),
		.pos_lim(pos_lim), .neg_lim(neg_lim), .ref_sw(ref_sw));

	lsfm_monitor #(.MIN_CYC(MIN)) u_dut (.core_clk(core_clk), .rstn(rstn),
		.positive_limit_input(pos_lim), .negative_limit_input(neg_lim),
		.ref_switch_input(ref_sw), .motion(motion), .err_clear(err_clear),
		.err_q(err_q), .err_code_q(err_code_q), .err_class_q(err_class_q),
		.status_q(status_q));

	// Code of the lowest pending error.
	function automatic logic [15:0] code_of(input lsfm_pkg::lsfm_err_t x);
		code_of = lsfm_pkg::ERR_NONE;
		if (x.neg_brief) code_of = lsfm_pkg::ERR_NEG_BRIEF;
		if (x.pos_brief) code_of = lsfm_pkg::ERR_POS_BRIEF;
		if (x.ref_brief) code_of = lsfm_pkg::ERR_REF_BRIEF;
		if (x.neg_dir) code_of = lsfm_pkg::ERR_NEG_DIR;
		if (x.pos_dir) code_of = lsfm_pkg::ERR_POS_DIR;
		if (x.multi) code_of = lsfm_pkg::ERR_MULTI;
	endfunction : code_of

	task automatic check(input string n, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask : check

	// Compares every error output with the expected latched set.
	task automatic expect_err(input lsfm_pkg::lsfm_err_t x);
		@(negedge core_clk);
		check("err_q", 16'(err_q), 16'(x));
		check("err_code_q", err_code_q, code_of(x));
		check("err_class_q", 16'(err_class_q), (x != '0) ? 16'h0001 : 16'h0000);
		check("status_q", status_q, 16'(x != '0) << lsfm_pkg::STATUS_ERR_BIT);
	endtask : expect_err

	task automatic pulse(input logic [2:0] sw, input int len,
		input lsfm_pkg::lsfm_motion_t mv);
		@(posedge core_clk);
		motion <= mv;
		sw_cmd <= sw;
		repeat (len) @(posedge core_clk);
		sw_cmd <= 3'h0;
		repeat (10) @(posedge core_clk);
		motion <= '0;
	endtask : pulse

	task automatic clear_all();
		@(posedge core_clk);
		err_clear <= 1'b1;
		@(posedge core_clk);
		err_clear <= 1'b0;
	endtask : clear_all

	task automatic close_out();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// Cuts a hang short well after the tests should be over.
	initial
	begin
		#(8 * 5000);
		failures++;
		close_out();
	end

	// Main sequence of tests.
	initial
	begin
		void'($urandom(78));
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		expect_err('0);
		for (int ch = 0; ch < 3; ch++)
		begin
			pulse(3'(1 << ch), $urandom_range(1, 5), '0);
			e = lsfm_pkg::lsfm_err_t'(ch == 0 ? 6'h10 : ch == 1 ? 6'h20 : 6'h08);
			repeat (20) @(posedge core_clk);
			expect_err(e);
			clear_all();
			expect_err('0);
		end
		pulse(3'h1, 12, '0);
		expect_err('0);
		$display("brief pulse test done");
		for (int s = 0; s < 2; s++)
		for (int d = 0; d < 2; d++)
		begin
			pulse(3'(1 << s), $urandom_range(2, 5),
				lsfm_pkg::lsfm_motion_t'({1'b1, d[0]}));
			e = '0;
			e.pos_dir = (s == 0 && d == 1);
			e.neg_dir = (s == 1 && d == 0);
			e.pos_brief = (s == 0);
			e.neg_brief = (s == 1);
			expect_err(e);
			clear_all();
		end
		$display("direction test done");
		for (int p = 3; p < 8; p++)
		begin
			if (p == 4)
				continue;
			pulse(3'(p), $urandom_range(1, 5), '0);
			expect_err(lsfm_pkg::lsfm_err_t'({p[1], p[0], p[2], 3'h1}));
			clear_all();
		end
		@(posedge core_clk);
		sw_cmd <= 3'h3;
		repeat (8) @(posedge core_clk);
		clear_all();
		expect_err(lsfm_pkg::lsfm_err_t'(6'h01));
		@(posedge core_clk);
		sw_cmd <= 3'h0;
		repeat (10) @(posedge core_clk);
		clear_all();
		expect_err('0);
		$display("multi switch test done");
		close_out();
	end
endmodule : limit_switch_fault_monitor_tb
`default_nettype wire
